/* hdl/clb_pkg.sv */
package clb_pkg;

    // ==========================================================
    // cycle status codes, also used as the request kind
    localparam logic [2:0] CS_IRQ_ACK = 3'h0;
    localparam logic [2:0] CS_IO_RD   = 3'h1;
    localparam logic [2:0] CS_IO_WR   = 3'h2;
    localparam logic [2:0] CS_HALT    = 3'h3;
    localparam logic [2:0] CS_FETCH   = 3'h4;
    localparam logic [2:0] CS_MEM_RD  = 3'h5;
    localparam logic [2:0] CS_MEM_WR  = 3'h6;
    localparam logic [2:0] CS_PASSIVE = 3'h7;

    // ==========================================================
    // segment codes as {upper bit 1, upper bit 0}
    localparam logic [1:0] SEG_ALT   = 2'h0;
    localparam logic [1:0] SEG_STACK = 2'h1;
    localparam logic [1:0] SEG_CODE  = 2'h2;
    localparam logic [1:0] SEG_DATA  = 2'h3;

    // ==========================================================
    // queue activity codes
    localparam logic [1:0] QS_NOP   = 2'h0;
    localparam logic [1:0] QS_FIRST = 2'h1;
    localparam logic [1:0] QS_EMPTY = 2'h2;
    localparam logic [1:0] QS_NEXT  = 2'h3;

    // ==========================================================
    // upper address/status field positions
    localparam int UAS_SEG_LSB = 0;
    localparam int UAS_IE_BIT  = 2;
    localparam int UAS_TOP_BIT = 3;

    // ==========================================================
    // counts and fixed values
    localparam logic [3:0]  RESET_SEQ_CYCLES = 4'hA;
    localparam int          RESET_MIN_CYCLES = 4;
    localparam int          NMI_MIN_CYCLES   = 2;
    localparam int          SYNC_STAGES      = 2;
    localparam logic [19:0] RESET_VECTOR     = 20'hFFFF0;
    localparam logic [7:0]  NMI_TYPE         = 8'h02;
    localparam logic [3:0]  IO_UPPER_ADDR    = 4'h0;

    // ==========================================================
    typedef enum logic [3:0] {
        ST_RST,
        ST_IDLE,
        ST_T1,
        ST_T2,
        ST_T3,
        ST_TW,
        ST_T4,
        ST_GRANT,
        ST_HOLD
    } clb_state_t;

endpackage

/* hdl/clb_sync.sv */
`timescale 1ns/1ps
module clb_sync #(
    parameter int W = 3
) (
    input  wire logic         clock_i, // core clock
    input  wire logic         rst_i,   // synchronous reset
    input  wire logic [W-1:0] async_i, // raw levels
    output logic      [W-1:0] sync_o   // synchronised levels
);
    logic [W-1:0] stage1_q;
    logic [W-1:0] stage2_q;

    // ==========================================================
    // two flops; the first is read only by the second
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            stage1_q <= '0;
            stage2_q <= '0;
        end else begin
            stage1_q <= async_i;
            stage2_q <= stage1_q;
        end
    end

    assign sync_o = stage2_q;
endmodule

/* hdl/clb_bus_if.sv */
// Operation
// - low byte carries address in T1, data in T2, T3, waits, T4
// - low byte and middle address float in interrupt ack and hold
// - middle address byte stays valid on its own lines except in interrupt ack and hold
// - upper bits: address in T1, zero for I/O, status afterwards
// - two status bits encode segment: alt, stack, code, data
// - active-low read and write strobes, floating during hold
// - ready sampled in T3 and waits, ignored in halt; low inserts wait states
// - maskable request is level, synchronised, sampled at instruction end
// - wait instruction idles while test input is high
// - non-maskable request is synchronised, type 2, needs two clocks
// - reset initialises at once; held at least four clocks
// - mode select high gives minimum mode, low gives maximum mode
// - maximum mode three-bit cycle status, floats during hold
// - cycle status goes passive in the state before T4
// - maximum mode request/grant lines carry request and grant
// - active-low lock output, floats during hold
// - two queue status outputs report queue activity
// - minimum mode space select low memory, high I/O, floats in hold
// - interrupt ack runs two back-to-back cycles, bus floating
// - minimum mode address latch pulse, never floated
// - transceiver direction and enable, floating during hold
// - minimum mode hold request answered by hold grant
// - bus cycle has T1 to T4 with waits between T3 and T4
// - after reset falls, ten clocks, then fetch from reset vector
`timescale 1ns/1ps
module clb_bus_if (
    input  wire logic        clock_i,                // core clock
    input  wire logic        rst_i,                  // synchronous reset
    input  wire logic        mode_select_i,          // 1 minimum, 0 maximum
    input  wire logic        req_valid_i,            // core bus request
    input  wire logic [2:0]  req_kind_i,             // cycle status code
    input  wire logic [19:0] req_addr_i,             // byte address
    input  wire logic [7:0]  req_wdata_i,            // write byte
    input  wire logic [1:0]  req_seg_i,              // segment code
    input  wire logic        lock_i,                 // core asks for lock
    input  wire logic        ie_flag_i,              // interrupt enable flag
    input  wire logic [1:0]  queue_op_i,             // queue activity
    input  wire logic        instr_last_i,           // last clock of instruction
    input  wire logic        wait_instr_i,           // wait instruction running
    input  wire logic        nmi_taken_i,            // core took the nmi
    output logic             req_ready_o,            // request taken
    output logic             rsp_valid_o,            // read data pulse
    output logic [7:0]       rsp_data_o,             // read byte
    output logic             boot_start_o,           // start fetch pulse
    output logic [19:0]      boot_addr_o,            // fetch start address
    output logic             maskable_irq_req_o,             // maskable request seen
    output logic             nmi_pending_o,          // nmi waiting
    output logic [7:0]       nmi_type_o,             // nmi vector type
    output logic             wait_idle_o,            // core must idle
    input  wire logic [7:0]  mux_addr_data_low_i,    // low byte pins in
    output logic [7:0]       mux_addr_data_low_o,    // low byte pins out
    output logic             mux_addr_data_low_oe_o, // low byte drive
    output logic [7:0]       addr_mid_byte_o,        // middle address
    output logic             addr_mid_byte_oe_o,     // middle drive
    output logic [3:0]       upper_addr_status_o,    // upper address/status
    output logic             upper_addr_status_oe_o, // upper drive
    output logic             rd_n_o,                 // read strobe
    output logic             rd_n_oe_o,              // read strobe drive
    output logic             wr_n_o,                 // write strobe
    output logic             wr_n_oe_o,              // write strobe drive
    output logic             irq_ack_n_o,            // ack read strobe
    output logic             irq_ack_n_oe_o,         // ack strobe drive
    output logic             ale_o,                  // address latch pulse
    output logic             space_sel_o,            // 1 I/O, 0 memory
    output logic             space_sel_oe_o,         // space select drive
    output logic             status_zero_min_o,      // status bit 0
    output logic             xcvr_direction_o,       // 1 transmit
    output logic             xcvr_direction_oe_o,    // direction drive
    output logic             xcvr_enable_n_o,        // transceiver enable
    output logic             xcvr_enable_n_oe_o,     // enable drive
    input  wire logic        hold_req_i,             // hold request
    output logic             hold_grant_o,           // hold granted
    input  wire logic        ready_i,                // addressed device ready
    input  wire logic        maskable_irq_i,         // maskable request
    input  wire logic        nmi_i,                  // non-maskable request
    input  wire logic        test_i,                 // test input
    output logic [2:0]       cycle_status_o,         // cycle status
    output logic             cycle_status_oe_o,      // cycle status drive
    output logic             lock_n_o,               // bus lock
    output logic             lock_n_oe_o,            // lock drive
    output logic [1:0]       queue_state_o,          // queue status
    input  wire logic        req_grant_0_i,          // request/grant 0 in
    output logic             req_grant_0_o,          // request/grant 0 out
    output logic             req_grant_0_oe_o,       // request/grant 0 drive
    input  wire logic        req_grant_1_i,          // request/grant 1 in
    output logic             req_grant_1_o,          // request/grant 1 out
    output logic             req_grant_1_oe_o        // request/grant 1 drive
);
    // ==========================================================
    // state
    clb_pkg::clb_state_t st_q;
    clb_pkg::clb_state_t st_d;
    logic [3:0]          cnt_q;
    logic [2:0]          kind_q;
    logic [19:0]         addr_q;
    logic [7:0]          wdata_q;
    logic [1:0]          seg_q;
    logic                ack2_q;
    logic                ie_q;
    logic                lockreq_q;
    logic [7:0]          rdata_q;
    logic                rsp_q;
    logic                boot_q;
    logic                rgsel_q;
    logic [1:0]          qs_q;
    logic                maskable_irq_q;
    logic                nmi_q;
    logic                nmi_s_q;
    logic [2:0]          sync_w;

    function automatic logic kind_reads(input logic [2:0] k);
        kind_reads = (k == clb_pkg::CS_IO_RD) || (k == clb_pkg::CS_MEM_RD)
                     || (k == clb_pkg::CS_FETCH);
    endfunction

    function automatic logic kind_writes(input logic [2:0] k);
        kind_writes = (k == clb_pkg::CS_IO_WR) || (k == clb_pkg::CS_MEM_WR);
    endfunction

    // ==========================================================
    // input synchronisers
    clb_sync #(
        .W (3)
    ) u_sync (
        .clock_i (clock_i),
        .rst_i   (rst_i),
        .async_i ({test_i, nmi_i, maskable_irq_i}),
        .sync_o  (sync_w)
    );

    // ==========================================================
    // decode
    wire min_mode  = mode_select_i;
    wire in_t1     = (st_q == clb_pkg::ST_T1);
    wire in_t2     = (st_q == clb_pkg::ST_T2);
    wire in_t3w    = (st_q == clb_pkg::ST_T3) || (st_q == clb_pkg::ST_TW);
    wire in_t4     = (st_q == clb_pkg::ST_T4);
    wire strobe_ph = in_t2 || in_t3w;
    wire data_ph   = strobe_ph || in_t4;
    wire active    = in_t1 || data_ph;
    wire floated   = (st_q == clb_pkg::ST_HOLD) || (st_q == clb_pkg::ST_GRANT);
    wire is_rd     = kind_reads(kind_q);
    wire is_wr     = kind_writes(kind_q);
    wire is_io     = (kind_q == clb_pkg::CS_IO_RD) || (kind_q == clb_pkg::CS_IO_WR);
    wire is_ack    = (kind_q == clb_pkg::CS_IRQ_ACK);
    wire is_halt   = (kind_q == clb_pkg::CS_HALT);
    wire cyc_done  = in_t3w && (is_halt || ready_i);
    wire ack_first = active && is_ack && !ack2_q;
    wire rq0       = !req_grant_0_i;
    wire rq1       = !req_grant_1_i;
    wire hold_ask  = min_mode ? hold_req_i : (rq0 || rq1);
    wire bus_free  = (st_q == clb_pkg::ST_IDLE) || in_t4;
    wire no_yield  = lockreq_q || (in_t4 && is_ack && !ack2_q);
    wire take_hold = bus_free && hold_ask && !no_yield;
    wire next_ack2 = in_t4 && is_ack && !ack2_q;
    wire accept    = bus_free && !take_hold && !next_ack2 && req_valid_i;
    wire rel_rg    = rgsel_q ? rq1 : rq0;
    wire nmi_rise  = sync_w[1] && !nmi_s_q;

    // ==========================================================
    // next state
    always_comb begin
        st_d = st_q;
        case (st_q)
            clb_pkg::ST_RST: begin
                if (cnt_q == clb_pkg::RESET_SEQ_CYCLES - 4'h1) begin
                    st_d = clb_pkg::ST_IDLE;
                end
            end
            clb_pkg::ST_IDLE, clb_pkg::ST_T4: begin
                if (next_ack2 || accept) begin
                    st_d = clb_pkg::ST_T1;
                end else if (take_hold) begin
                    st_d = min_mode ? clb_pkg::ST_HOLD : clb_pkg::ST_GRANT;
                end else begin
                    st_d = clb_pkg::ST_IDLE;
                end
            end
            clb_pkg::ST_T1: st_d = clb_pkg::ST_T2;
            clb_pkg::ST_T2: st_d = clb_pkg::ST_T3;
            clb_pkg::ST_T3, clb_pkg::ST_TW: begin
                st_d = cyc_done ? clb_pkg::ST_T4 : clb_pkg::ST_TW;
            end
            clb_pkg::ST_GRANT: st_d = clb_pkg::ST_HOLD;
            clb_pkg::ST_HOLD: begin
                if (min_mode ? !hold_req_i : rel_rg) begin
                    st_d = clb_pkg::ST_IDLE;
                end
            end
            default: st_d = clb_pkg::ST_RST;
        endcase
    end

    // ==========================================================
    // registers, all static flip-flops
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            st_q <= clb_pkg::ST_RST;
            cnt_q <= 4'h0;
            boot_q <= 1'b0;
        end else begin
            st_q <= st_d;
            cnt_q <= (st_q == clb_pkg::ST_RST) ? cnt_q + 4'h1 : 4'h0;
            boot_q <= (st_q == clb_pkg::ST_RST) && (st_d == clb_pkg::ST_IDLE);
        end
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            kind_q <= clb_pkg::CS_PASSIVE;
            addr_q <= 20'h00000;
            wdata_q <= 8'h00;
            seg_q <= clb_pkg::SEG_CODE;
            ack2_q <= 1'b0;
        end else if (accept) begin
            kind_q <= req_kind_i;
            addr_q <= (req_kind_i == clb_pkg::CS_IRQ_ACK) ? 20'h00000 : req_addr_i;
            wdata_q <= req_wdata_i;
            seg_q <= req_seg_i;
            ack2_q <= 1'b0;
        end else if (next_ack2) begin
            ack2_q <= 1'b1;
        end
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            ie_q <= 1'b0;
            lockreq_q <= 1'b0;
            qs_q <= clb_pkg::QS_NOP;
            rgsel_q <= 1'b0;
        end else begin
            ie_q <= ie_flag_i;
            lockreq_q <= lock_i;
            qs_q <= queue_op_i;
            if (take_hold && !min_mode) begin
                rgsel_q <= !rq0;
            end
        end
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            rdata_q <= 8'h00;
            rsp_q <= 1'b0;
        end else begin
            rsp_q <= cyc_done && (is_rd || (is_ack && ack2_q));
            if (cyc_done && (is_rd || is_ack)) begin
                rdata_q <= mux_addr_data_low_i;
            end
        end
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            maskable_irq_q <= 1'b0;
            nmi_q <= 1'b0;
            nmi_s_q <= 1'b0;
        end else begin
            nmi_s_q <= sync_w[1];
            nmi_q <= nmi_rise || (nmi_q && !nmi_taken_i);
            if (instr_last_i) begin
                maskable_irq_q <= sync_w[0] && ie_flag_i;
            end else if (accept && req_kind_i == clb_pkg::CS_IRQ_ACK) begin
                maskable_irq_q <= 1'b0;
            end
        end
    end

    // ==========================================================
    // core side outputs
    assign req_ready_o   = accept;
    assign rsp_valid_o   = rsp_q;
    assign rsp_data_o    = rdata_q;
    assign boot_start_o  = boot_q;
    assign boot_addr_o   = clb_pkg::RESET_VECTOR;
    assign maskable_irq_req_o    = maskable_irq_q;
    assign nmi_pending_o = nmi_q;
    assign nmi_type_o    = clb_pkg::NMI_TYPE;
    assign wait_idle_o   = wait_instr_i && sync_w[2];

    // ==========================================================
    // address and data pins
    wire ack_cyc = active && is_ack;
    assign mux_addr_data_low_o    = in_t1 ? addr_q[7:0] : wdata_q;
    assign mux_addr_data_low_oe_o = !floated && !ack_cyc
                                    && (in_t1 || (data_ph && is_wr));
    assign addr_mid_byte_o        = addr_q[15:8];
    assign addr_mid_byte_oe_o     = !floated && !ack_cyc;
    wire [3:0] uas_stat = {1'b0, ie_q, seg_q};
    assign upper_addr_status_o    = in_t1 ? (is_io ? clb_pkg::IO_UPPER_ADDR
                                    : addr_q[19:16]) : uas_stat;
    assign upper_addr_status_oe_o = !floated;

    // ==========================================================
    // minimum mode control pins; read strobe driven in both modes
    assign rd_n_o              = !(strobe_ph && is_rd);
    assign rd_n_oe_o           = !floated;
    assign wr_n_o              = !(data_ph && is_wr);
    assign wr_n_oe_o           = min_mode && !floated;
    assign irq_ack_n_o         = !(strobe_ph && is_ack);
    assign irq_ack_n_oe_o      = min_mode && !floated;
    assign ale_o               = min_mode && in_t1;
    assign space_sel_o         = is_io || is_ack;
    assign space_sel_oe_o      = min_mode && !floated;
    assign status_zero_min_o   = cycle_status_o[0];
    assign xcvr_direction_o    = is_wr;
    assign xcvr_direction_oe_o = min_mode && !floated;
    assign xcvr_enable_n_o     = !((strobe_ph && (is_rd || is_ack))
                                   || (data_ph && is_wr));
    assign xcvr_enable_n_oe_o  = min_mode && !floated;
    assign hold_grant_o        = min_mode && (st_q == clb_pkg::ST_HOLD);

    // ==========================================================
    // maximum mode pins; queue status driven in both modes
    wire cs_live = in_t1 || in_t2 || (in_t3w && !cyc_done);
    assign cycle_status_o    = cs_live ? kind_q : clb_pkg::CS_PASSIVE;
    assign cycle_status_oe_o = !min_mode && !floated;
    wire lock_on = lockreq_q || (ack_first && !in_t1)
                   || (in_t1 && is_ack && ack2_q);
    assign lock_n_o         = !lock_on;
    assign lock_n_oe_o      = !min_mode && !floated;
    assign queue_state_o    = qs_q;
    wire grant_now = (st_q == clb_pkg::ST_GRANT);
    assign req_grant_0_o    = 1'b0;
    assign req_grant_0_oe_o = grant_now && !rgsel_q;
    assign req_grant_1_o    = 1'b0;
    assign req_grant_1_oe_o = grant_now && rgsel_q;

    // ==========================================================
    // checks
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (rst_i);

    property p_ad_addr;
        in_t1 && !is_ack |-> mux_addr_data_low_oe_o && mux_addr_data_low_o == addr_q[7:0];
    endproperty
    a_ad_addr: assert property (p_ad_addr) else $error("no address in T1");

    property p_ack_float;
        ack_cyc || floated |-> !mux_addr_data_low_oe_o && !addr_mid_byte_oe_o;
    endproperty
    a_ack_float: assert property (p_ack_float) else $error("bus driven");

    property p_io_upper;
        in_t1 && is_io |-> upper_addr_status_o == 4'h0;
    endproperty
    a_io_upper: assert property (p_io_upper) else $error("io upper set");

    property p_seg;
        in_t2 |-> upper_addr_status_o[1:0] == seg_q && upper_addr_status_o[2] == ie_q;
    endproperty
    a_seg: assert property (p_seg) else $error("bad segment status");

    property p_rd;
        in_t1 && is_rd |=> !rd_n_o ##1 !rd_n_o;
    endproperty
    a_rd: assert property (p_rd) else $error("read strobe missing");

    property p_wait;
        st_q == clb_pkg::ST_T3 && !ready_i && !is_halt |=> st_q == clb_pkg::ST_TW;
    endproperty
    a_wait: assert property (p_wait) else $error("wait not inserted");

    property p_passive;
        in_t4 |-> cycle_status_o == 3'h7 && $past(cycle_status_o) == 3'h7;
    endproperty
    a_passive: assert property (p_passive) else $error("status not passive");

    property p_boot;
        $fell(rst_i) |-> ##10 boot_start_o;
    endproperty
    a_boot: assert property (@(posedge clock_i) p_boot) else $error("boot late");

    property p_nmi;
        nmi_rise |=> nmi_pending_o;
    endproperty
    a_nmi: assert property (p_nmi) else $error("nmi lost");

    property p_hold;
        min_mode && st_q == clb_pkg::ST_HOLD |-> hold_grant_o && !rd_n_oe_o;
    endproperty
    a_hold: assert property (p_hold) else $error("hold not granted");

    property p_ale;
        min_mode && in_t1 |-> ale_o ##1 !ale_o;
    endproperty
    a_ale: assert property (p_ale) else $error("ale wrong");

    c_write: cover property (in_t4 && is_wr);
    c_wait: cover property (st_q == clb_pkg::ST_TW ##1 in_t4);
    c_ack2: cover property (in_t4 && is_ack && ack2_q);
    c_hold: cover property (st_q == clb_pkg::ST_HOLD);
endmodule

/* dv/clb_mem_model.sv */
`timescale 1ns/1ps
module clb_mem_model (
    input  wire logic       clock_i, // core clock
    input  wire logic       rd_n_i,  // read strobe
    input  wire logic       wr_n_i,  // write strobe
    input  wire logic [2:0] slow_i,  // stall cycles
    input  wire logic [7:0] rdata_i, // byte to return
    output logic            ready_o, // ready to block
    output logic [7:0]      ad_o     // byte back
);
    logic [2:0] cnt_q;
    always_ff @(posedge clock_i) cnt_q <= (rd_n_i & wr_n_i) ? 3'h0 : cnt_q + 3'h1;
    assign ready_o = cnt_q >= slow_i;
    // data only once ready, else a pattern that cannot pass for it
    assign ad_o = (!rd_n_i && ready_o) ? rdata_i : ~rdata_i;
endmodule

/* dv/clb_bus_if_test.sv */
`timescale 1ns/1ps
module clb_bus_if_test;
    // ======
    logic clock_i = 0, rst_i = 1, mode_select_i = 1, req_valid_i = 0, lock_i = 0, ph = 0;
    logic nmi_taken_i = 0, hold_req_i = 0, req_grant_0_i = 1, req_grant_1_i = 1, up = 0;
    logic ie_flag_i = 0, instr_last_i = 0, wait_instr_i = 0, maskable_irq_i = 0, nmi_i = 0;
    logic test_i = 0, t1 = 0, t2 = 0;
    logic n1 = 0, n2 = 0, n3 = 0, np = 0, i1 = 0, i2 = 0, ix = 0;
    logic [2:0] req_kind_i = 0, slow = 0, cycle_status_o;
    logic [1:0] req_seg_i = 0, queue_op_i = 0, qprev = 0, queue_state_o;
    logic [7:0] req_wdata_i = 0, mem_byte = 0, rsp_data_o, nmi_type_o, addr_mid_byte_o;
    logic [7:0] mux_addr_data_low_i, mux_addr_data_low_o;
    logic [19:0] req_addr_i = 0, boot_addr_o;
    logic [3:0] upper_addr_status_o;
    logic req_ready_o, rsp_valid_o, boot_start_o, maskable_irq_req_o, nmi_pending_o, wait_idle_o;
    logic mux_addr_data_low_oe_o, addr_mid_byte_oe_o, upper_addr_status_oe_o, rd_n_o, rd_n_oe_o;
    logic wr_n_o, wr_n_oe_o, irq_ack_n_o, irq_ack_n_oe_o, ale_o, space_sel_o, space_sel_oe_o;
    logic status_zero_min_o, xcvr_direction_o, xcvr_direction_oe_o, xcvr_enable_n_o;
    logic xcvr_enable_n_oe_o, hold_grant_o, ready_i, cycle_status_oe_o, lock_n_o, lock_n_oe_o;
    logic req_grant_0_o, req_grant_0_oe_o, req_grant_1_o, req_grant_1_oe_o;
    int errors = 0, total_checks = 0, n = 0;
    integer seed = 32'h56194F56;
    logic [7:0] expq[$];
    logic [2:0] kinds[5] = '{3'h4, 3'h5, 3'h6, 3'h1, 3'h2};

    clb_bus_if dut_u (.*);
    clb_mem_model mem_u (.clock_i(clock_i), .rd_n_i(rd_n_o), .wr_n_i(wr_n_o), .slow_i(slow),
        .rdata_i(mem_byte), .ready_o(ready_i), .ad_o(mux_addr_data_low_i));
    always #2 clock_i = ~clock_i;

    always @(posedge clock_i) begin
        {nmi_taken_i, queue_op_i, instr_last_i, wait_instr_i, test_i, ie_flag_i}
            <= 7'($random(seed));
        ph <= ~ph;
        if (ph) nmi_i <= 1'($random(seed));
        qprev <= queue_op_i;
        t1 <= test_i;
        t2 <= t1;
        // expected interrupt flags: two-flop sync, edge detect, sample at instruction end
        if (rst_i) begin
            {n1, n2, n3, np, i1, i2, ix} <= 7'h00;
        end else begin
            {n1, n2, n3, i1, i2} <= {nmi_i, n1, n2, maskable_irq_i, i1};
            np <= (n2 & ~n3) | (np & ~nmi_taken_i);
            if (instr_last_i) ix <= i2 & ie_flag_i;
        end
    end

    task automatic check(input string what, input logic [19:0] seen, input logic [19:0] exp);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH %s exp %h seen %h", what, exp, seen);
        end
    endtask

    task automatic print_verdict;
        if (errors == 0 && total_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic wait_hi(ref logic sig, input logic v = 1'b1);
        @(negedge clock_i);
        for (n = 1; n < 40 && sig !== v; n++) @(negedge clock_i);
        if (n >= 40) begin
            errors++;
            print_verdict();
        end
    endtask

    task automatic bus(input logic [2:0] k, input logic [2:0] s);
        @(posedge clock_i);
        req_kind_i <= k;
        req_addr_i <= 20'($random(seed));
        {req_wdata_i, mem_byte, req_seg_i} <= 18'($random(seed));
        slow <= s;
        req_valid_i <= 1'b1;
        wait_hi(req_ready_o);
        if (!k[1]) expq.push_back(mem_byte);
        @(posedge clock_i);
        req_valid_i <= 1'b0;
        @(negedge clock_i);
        check("t1", {ale_o, cycle_status_o}, {mode_select_i, k});
        // hold the drivers until the strobe of this cycle has come and gone
        if (k[1]) begin
            wait_hi(wr_n_o, 1'b0);
            wait_hi(wr_n_o);
        end else begin
            wait_hi(rd_n_o, 1'b0);
            wait_hi(rd_n_o);
        end
    endtask

    always @(negedge clock_i) if (up) begin
        if (ale_o) begin
            check("ad addr", mux_addr_data_low_o, req_addr_i[7:0]);
            check("mid addr", addr_mid_byte_o, req_addr_i[15:8]);
            check("top", upper_addr_status_o, req_kind_i[2] ? req_addr_i[19:16] : 4'h0);
            check("space", space_sel_o, !req_kind_i[2]);
            check("status", status_zero_min_o, req_kind_i[0]);
        end
        if (!wr_n_o) check("wdata", mux_addr_data_low_o, req_wdata_i);
        if (!rd_n_o || !wr_n_o) check("seg", upper_addr_status_o[1:0], req_seg_i);
        if (rsp_valid_o) check("rdata", rsp_data_o, expq.size() ? expq.pop_front() : 8'hXX);
        check("queue", queue_state_o, qprev);
        check("idle", wait_idle_o, wait_instr_i & t2);
        check("irq", {maskable_irq_req_o, nmi_pending_o, nmi_type_o}, {ix, np, 8'h02});
    end

    initial begin
        repeat (4) @(posedge clock_i);
        rst_i <= 1'b0;
        wait_hi(boot_start_o);
        check("boot delay", n, 11);
        check("boot addr", boot_addr_o, 20'hFFFF0);
        @(posedge clock_i);
        up <= 1'b1;
        maskable_irq_i <= 1'b1;
        foreach (kinds[i]) bus(kinds[i], 3'h0);
        foreach (kinds[i]) bus(kinds[i], 3'h3);
        @(posedge clock_i);
        hold_req_i <= 1'b1;
        wait_hi(hold_grant_o);
        check("hold", {mux_addr_data_low_oe_o, addr_mid_byte_oe_o, rd_n_oe_o, wr_n_oe_o,
            xcvr_enable_n_oe_o, upper_addr_status_oe_o, space_sel_oe_o}, 7'h0);
        @(posedge clock_i);
        hold_req_i <= 1'b0;
        wait_hi(hold_grant_o, 1'b0);
        bus(3'h5, 3'h1);
        @(posedge clock_i);
        check("left", expq.size(), 0);
        // second reset in mid-run, coming out in maximum mode
        rst_i <= 1'b1;
        up <= 1'b0;
        mode_select_i <= 1'b0;
        repeat (4) @(posedge clock_i);
        rst_i <= 1'b0;
        wait_hi(boot_start_o);
        check("boot again", n, 11);
        @(posedge clock_i);
        up <= 1'b1;
        foreach (kinds[i]) bus(kinds[i], 3'h1);
        @(posedge clock_i);
        req_grant_0_i <= 1'b0;
        @(posedge clock_i);
        req_grant_0_i <= 1'b1;
        wait_hi(req_grant_0_oe_o);
        check("grant", {req_grant_0_o, req_grant_1_oe_o, cycle_status_oe_o, lock_n_oe_o},
            4'h0);
        @(posedge clock_i);
        req_grant_0_i <= 1'b0;
        @(posedge clock_i);
        req_grant_0_i <= 1'b1;
        wait_hi(cycle_status_oe_o);
        print_verdict();
    end
endmodule
